// [hw/pqs_map.vh]
// register offsets, field positions and reset values of the quick status block
`ifndef PQS_MAP_VH
`define PQS_MAP_VH

`define PQS_ADDR_W 5
`define PQS_DATA_W 16
`define PQS_OFS_QUICK_STATUS 5'h11
`define PQS_OFS_TEN_BT_OPS 5'h12
`define PQS_OFS_VENDOR_LO 5'h19
`define PQS_OFS_VENDOR_HI 5'h1F

// quick poll detailed status fields
`define PQS_QS_PROG_HI 13
`define PQS_QS_PROG_LO 11
`define PQS_QS_SIG_LOST 10
`define PQS_QS_PLL_ERR 9
`define PQS_QS_FALSE_CARRIER 8
`define PQS_QS_INVALID_SYM 7
`define PQS_QS_HALT_SYM 6
`define PQS_QS_PREMATURE_END 5
`define PQS_QS_AN_DONE 4
`define PQS_QS_NO_SIGNAL 3
`define PQS_QS_JABBER 2
`define PQS_QS_REMOTE_FAULT 1
`define PQS_QS_LINK 0

// ten base t operations fields
`define PQS_OP_REMOTE_JABBER 15
`define PQS_OP_POLARITY_REV 14
`define PQS_OP_BUS_MODE_HI 13
`define PQS_OP_BUS_MODE_LO 12
`define PQS_OP_AUTO_XOVER 11
`define PQS_OP_RX_FLOAT 10
`define PQS_OP_VENDOR_GATE 9
`define PQS_OP_TEST_MUX 8
`define PQS_OP_RSVD_ONE 4
`define PQS_OP_JABBER_OFF 5

// reset values
`define PQS_RST_PROG 3'h0
`define PQS_RST_NO_SIGNAL 1'h1
`define PQS_RST_FLAG 1'h0
`define PQS_RST_TEST_MUX 1'h0
`define PQS_RST_JABBER_OFF 1'h0
`define PQS_RST_RSVD_ONE 1'h1

// data bus mode codes
`define PQS_MODE_MII 2'h0
`define PQS_MODE_SERIAL 2'h1

`endif

// [hw/pqs_regs.v]
// quick poll status and 10base-t operations register bank
`timescale 1ns/1ps
`include "pqs_map.vh"

// Function
// RQ1 - bit 11 carries lowest progress bit; bit 4 shows negotiation complete.
// RQ2 - three-bit progress code in bits 13:11, read-only, reset zero.
// RQ3 - signal lost, pll error, false carrier latch high; no-signal live, resets one.
// RQ4 - invalid and halt code group flags latch high, reset zero.
// RQ5 - premature end flag latches high on two idles in data.
// RQ6 - remote fault, jabber, remote jabber latch high; link latched low; jabber inhibit.
// RQ7 - bit 18.13 shows receive float strap captured at reset.
// RQ8 - bus mode 18.13:12 from straps; 00 mii, 01 serial, 1x unsupported.
// RQ9 - 18.10 floats receive outputs, 18.11 crossover, strap defaults, polarity latch.
// RQ10 - 18.9 zero allows vendor registers 25 to 31, one blocks them.
// RQ11 - 18.8 selects test mux routing, resets zero.
// RQ12 - latched flags hold until read, then follow the live condition.
module pqs_regs
(
	input wire CLOCK, // management clock
	input wire RSTN, // async reset, active low
	input wire [`PQS_ADDR_W-1:0] REG_ADDR, // register number
	input wire REG_RD, // read strobe, one cycle
	input wire REG_WR, // write strobe, one cycle
	input wire [`PQS_DATA_W-1:0] REG_WDATA, // write data
	output reg [`PQS_DATA_W-1:0] REG_RDATA, // read data, valid cycle after strobe
	output wire VENDOR_BLOCKED, // access to vendor space refused
	input wire [2:0] AN_PROGRESS, // live negotiation progress code
	input wire AN_DONE, // negotiation complete
	input wire SIG_LOST_EV, // 100 mb/s signal lost
	input wire PLL_ERR_EV, // receive pll lock failure
	input wire FALSE_CARRIER_EV, // false carrier seen
	input wire INVALID_SYM_EV, // invalid code group
	input wire HALT_SYM_EV, // halt code group
	input wire PREMATURE_END_EV, // two idles inside data
	input wire NO_SIGNAL, // live signal absence
	input wire JABBER_EV, // jabber seen
	input wire REMOTE_FAULT_EV, // remote fault seen
	input wire LINK_UP, // live link valid
	input wire REMOTE_JABBER_EV, // remote jabber seen
	input wire POLARITY_REV_EV, // polarity reversal seen
	input wire STRAP_RX_FLOAT, // receive float strap
	input wire STRAP_SERIAL, // serial interface strap
	input wire STRAP_AUTO_XOVER, // crossover strap
	input wire STRAP_VENDOR_GATE, // vendor gate strap
	output wire AUTO_CROSSOVER_ENABLE, // crossover enabled
	output wire RECEIVE_OUTPUT_FLOAT, // receive outputs floated
	output wire RX_OE_N, // receive output enable, low drives
	output wire VENDOR_SPACE_GATE, // vendor space gate bit
	output wire TEST_MUX_SELECT, // test mux routing
	output wire JABBER_CHECK_OFF, // jabber check disabled
	output wire [1:0] BUS_MODE // data bus mode code
);

	reg strap_done_r;
	reg strap_rx_float_r;
	reg strap_serial_r;
	reg auto_xover_r;
	reg rx_float_r;
	reg vendor_gate_r;
	reg test_mux_r;
	reg jabber_off_r;
	reg [2:0] prog_r;
	reg [2:0] prog_nxt;
	reg link_r;
	reg no_signal_r;
	reg an_done_r;
	// latched high flags: index order below
	reg [9:0] flag_r;
	wire [9:0] flag_ev;
	wire rd_qs;
	wire rd_op;
	wire wr_op;
	wire [`PQS_DATA_W-1:0] qs_val;
	wire [`PQS_DATA_W-1:0] op_val;
	wire in_vendor;
	reg [`PQS_DATA_W-1:0] rdata_nxt;

	// positions of the latched high flags in flag_r
	localparam FL_SIG_LOST = 0;
	localparam FL_PLL_ERR = 1;
	localparam FL_FALSE_CARRIER = 2;
	localparam FL_INVALID_SYM = 3;
	localparam FL_HALT_SYM = 4;
	localparam FL_PREMATURE_END = 5;
	localparam FL_JABBER = 6;
	localparam FL_REMOTE_FAULT = 7;
	localparam FL_REMOTE_JABBER = 8;
	localparam FL_POLARITY_REV = 9;
	localparam FL_COUNT = 10;

	assign rd_qs = REG_RD && (REG_ADDR == `PQS_OFS_QUICK_STATUS);
	assign rd_op = REG_RD && (REG_ADDR == `PQS_OFS_TEN_BT_OPS);
	assign wr_op = REG_WR && (REG_ADDR == `PQS_OFS_TEN_BT_OPS);

	// RQ3 latched event inputs
	assign flag_ev[0] = SIG_LOST_EV;
	assign flag_ev[1] = PLL_ERR_EV;
	assign flag_ev[2] = FALSE_CARRIER_EV;
	// RQ4 code group events
	assign flag_ev[3] = INVALID_SYM_EV;
	assign flag_ev[4] = HALT_SYM_EV;
	// RQ5 premature end event
	assign flag_ev[5] = PREMATURE_END_EV;
	// RQ6 jabber gated by inhibit
	assign flag_ev[6] = JABBER_EV && !jabber_off_r;
	assign flag_ev[7] = REMOTE_FAULT_EV;
	assign flag_ev[8] = REMOTE_JABBER_EV;
	// RQ9 polarity reversal event
	assign flag_ev[9] = POLARITY_REV_EV;

	// RQ12 set wins over clear on read
	genvar gi;
	generate
		for (gi = 0; gi < FL_COUNT; gi = gi + 1)
		begin : g_flag
			wire clr;
			// ops register flags clear on an ops read, the rest on a status read
			assign clr = (gi >= FL_REMOTE_JABBER) ? rd_op : rd_qs;
			always @(posedge CLOCK or negedge RSTN)
			begin
				if (!RSTN)
					flag_r[gi] <= `PQS_RST_FLAG;
				else
					flag_r[gi] <= flag_ev[gi] | (flag_r[gi] & ~clr);
			end
		end
	endgenerate

	// RQ2 progress holds its highest value until read
	always @*
	begin
		prog_nxt = prog_r;
		if (rd_qs)
			prog_nxt = AN_PROGRESS;
		else if (AN_PROGRESS > prog_r)
			prog_nxt = AN_PROGRESS;
	end

	always @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			prog_r <= `PQS_RST_PROG;
			link_r <= `PQS_RST_FLAG;
			no_signal_r <= `PQS_RST_NO_SIGNAL;
			an_done_r <= 1'h0;
		end
		else
		begin
			prog_r <= prog_nxt;
			// RQ6 link latched low until read
			if (rd_qs)
				link_r <= LINK_UP;
			else
				link_r <= link_r & LINK_UP;
			// RQ3 live no-signal
			no_signal_r <= NO_SIGNAL;
			// RQ1 negotiation complete
			an_done_r <= AN_DONE;
		end
	end

	// straps captured on first edge after reset release
	always @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			strap_done_r <= 1'h0;
			strap_rx_float_r <= 1'h0;
			strap_serial_r <= 1'h0;
			auto_xover_r <= 1'h0;
			rx_float_r <= 1'h0;
			vendor_gate_r <= 1'h0;
			test_mux_r <= `PQS_RST_TEST_MUX;
			jabber_off_r <= `PQS_RST_JABBER_OFF;
		end
		else if (!strap_done_r)
		begin
			// writes in the capture cycle are lost
			strap_done_r <= 1'h1;
			// RQ7 capture float strap
			strap_rx_float_r <= STRAP_RX_FLOAT;
			// RQ8 capture serial strap
			strap_serial_r <= STRAP_SERIAL;
			// RQ9 strap defaults
			auto_xover_r <= STRAP_AUTO_XOVER;
			rx_float_r <= STRAP_RX_FLOAT;
			// RQ10 strap default gate
			vendor_gate_r <= STRAP_VENDOR_GATE;
		end
		else if (wr_op)
		begin
			// RQ9 writable crossover and float
			auto_xover_r <= REG_WDATA[`PQS_OP_AUTO_XOVER];
			rx_float_r <= REG_WDATA[`PQS_OP_RX_FLOAT];
			// RQ10 writable gate
			vendor_gate_r <= REG_WDATA[`PQS_OP_VENDOR_GATE];
			// RQ11 writable test mux select
			test_mux_r <= REG_WDATA[`PQS_OP_TEST_MUX];
			// RQ6 writable jabber inhibit
			jabber_off_r <= REG_WDATA[`PQS_OP_JABBER_OFF];
		end
	end

	// RQ2 progress code, top bits unused
	assign qs_val[15:14] = 2'h0;
	assign qs_val[`PQS_QS_PROG_HI:`PQS_QS_PROG_LO] = prog_r;

	// RQ3 signal, pll and carrier flags
	assign qs_val[`PQS_QS_SIG_LOST] = flag_r[FL_SIG_LOST];
	assign qs_val[`PQS_QS_PLL_ERR] = flag_r[FL_PLL_ERR];
	assign qs_val[`PQS_QS_FALSE_CARRIER] = flag_r[FL_FALSE_CARRIER];

	// RQ4 code group flags
	assign qs_val[`PQS_QS_INVALID_SYM] = flag_r[FL_INVALID_SYM];
	assign qs_val[`PQS_QS_HALT_SYM] = flag_r[FL_HALT_SYM];

	// RQ5 premature end flag
	assign qs_val[`PQS_QS_PREMATURE_END] = flag_r[FL_PREMATURE_END];

	// RQ1 negotiation complete bit
	assign qs_val[`PQS_QS_AN_DONE] = an_done_r;

	// RQ3 live signal absence
	assign qs_val[`PQS_QS_NO_SIGNAL] = no_signal_r;

	// RQ6 jabber, fault, link
	assign qs_val[`PQS_QS_JABBER] = flag_r[FL_JABBER];
	assign qs_val[`PQS_QS_REMOTE_FAULT] = flag_r[FL_REMOTE_FAULT];
	assign qs_val[`PQS_QS_LINK] = link_r;

	// RQ6 remote jabber flag
	assign op_val[`PQS_OP_REMOTE_JABBER] = flag_r[FL_REMOTE_JABBER];

	// RQ9 polarity reversal flag
	assign op_val[`PQS_OP_POLARITY_REV] = flag_r[FL_POLARITY_REV];

	// RQ7 float strap as mode high bit
	assign op_val[`PQS_OP_BUS_MODE_HI] = strap_rx_float_r;
	// RQ8 serial strap low bit
	assign op_val[`PQS_OP_BUS_MODE_LO] = strap_serial_r;

	// RQ9 crossover and receive float
	assign op_val[`PQS_OP_AUTO_XOVER] = auto_xover_r;
	assign op_val[`PQS_OP_RX_FLOAT] = rx_float_r;

	// RQ10 vendor gate bit
	assign op_val[`PQS_OP_VENDOR_GATE] = vendor_gate_r;

	// RQ11 test mux select
	assign op_val[`PQS_OP_TEST_MUX] = test_mux_r;

	// reserved bits 7:6 read zero
	assign op_val[7:6] = 2'h0;

	// RQ6 jabber inhibit bit
	assign op_val[`PQS_OP_JABBER_OFF] = jabber_off_r;
	assign op_val[`PQS_OP_RSVD_ONE] = `PQS_RST_RSVD_ONE;
	assign op_val[3:0] = 4'h0;

	// read data selected by register number
	always @*
	begin
		rdata_nxt = REG_RDATA;
		case (REG_ADDR)
			`PQS_OFS_QUICK_STATUS:
				if (REG_RD)
					rdata_nxt = qs_val;
			`PQS_OFS_TEN_BT_OPS:
				if (REG_RD)
					rdata_nxt = op_val;
			default:
				rdata_nxt = REG_RDATA;
		endcase
	end

	// unmapped reads leave the last word in place
	always @(posedge CLOCK or negedge RSTN)
	begin
		if (!RSTN)
			REG_RDATA <= 16'h0000;
		else
			REG_RDATA <= rdata_nxt;
	end

	// RQ10 vendor register window
	assign in_vendor = (REG_ADDR >= `PQS_OFS_VENDOR_LO) && (REG_ADDR <= `PQS_OFS_VENDOR_HI);

	// RQ10 vendor space refused while gate set
	assign VENDOR_BLOCKED = vendor_gate_r && (REG_RD || REG_WR) && in_vendor;

	// control levels straight from their registers
	assign AUTO_CROSSOVER_ENABLE = auto_xover_r;
	// RQ9 receive outputs float when set
	assign RECEIVE_OUTPUT_FLOAT = rx_float_r;
	assign RX_OE_N = rx_float_r;
	assign VENDOR_SPACE_GATE = vendor_gate_r;
	assign TEST_MUX_SELECT = test_mux_r;
	assign JABBER_CHECK_OFF = jabber_off_r;
	assign BUS_MODE = {strap_rx_float_r, strap_serial_r};

endmodule // pqs_regs

// [test/pqs_chk_sva.sv]
// assertions on the quick status register bank ports
`timescale 1ns/1ps
module pqs_chk
(
	input wire CLOCK, // clock
	input wire RSTN, // reset
	input wire [4:0] REG_ADDR, // address
	input wire REG_RD, // read
	input wire REG_WR, // write
	input wire [15:0] REG_WDATA, // wdata
	input wire [15:0] REG_RDATA, // rdata
	input wire VENDOR_BLOCKED, // refused
	input wire SIG_LOST_EV, // event
	input wire FALSE_CARRIER_EV, // event
	input wire AUTO_CROSSOVER_ENABLE, // ctl
	input wire RECEIVE_OUTPUT_FLOAT, // ctl
	input wire RX_OE_N, // ctl
	input wire VENDOR_SPACE_GATE, // ctl
	input wire TEST_MUX_SELECT, // ctl
	input wire JABBER_CHECK_OFF, // ctl
	input wire [1:0] BUS_MODE // mode
);
default clocking @(posedge CLOCK); endclocking
default disable iff (!RSTN);
wire rd17 = REG_RD && REG_ADDR == 5'h11;
wire rd18 = REG_RD && REG_ADDR == 5'h12;
wire wr18 = REG_WR && REG_ADDR == 5'h12;
wire [9:0] opx = {BUS_MODE, AUTO_CROSSOVER_ENABLE, RECEIVE_OUTPUT_FLOAT,
	VENDOR_SPACE_GATE, TEST_MUX_SELECT, 2'b00, JABBER_CHECK_OFF, 1'b1};
wire [5:0] cur = {opx[7:4], RX_OE_N, JABBER_CHECK_OFF};
wire [5:0] wsel = {REG_WDATA[11:8], REG_WDATA[10], REG_WDATA[5]};
ops_read_a: assert property (rd18 |=> REG_RDATA[13:4] == $past(opx))
	else $error("ops word mismatch");
ctl_write_a: assert property (wr18 |=> cur == $past(wsel))
	else $error("control write mismatch");
mux_source_a: assert property ($changed(TEST_MUX_SELECT) |-> $past(wr18))
	else $error("test mux changed without write");
vend_block_a: assert property (VENDOR_BLOCKED == (VENDOR_SPACE_GATE
	&& (REG_RD || REG_WR) && REG_ADDR >= 5'h19)) else $error("vendor gate wrong");
vend_rdata_a: assert property (REG_RD && REG_ADDR == 5'h19 |=> $stable(REG_RDATA))
	else $error("unmapped read changed data");
top_zero_a: assert property (rd17 |=> REG_RDATA[15:14] == 2'b00)
	else $error("status top bits set");
carrier_latch_a: assert property (FALSE_CARRIER_EV ##1 rd17 |=> REG_RDATA[8])
	else $error("false carrier not latched");
lost_latch_a: assert property (SIG_LOST_EV ##1 rd17 |=> REG_RDATA[10])
	else $error("signal lost not latched");
cover property (wr18 ##1 rd18);
cover property (FALSE_CARRIER_EV ##1 rd17);
cover property (VENDOR_BLOCKED);
endmodule // pqs_chk
bind pqs_regs pqs_chk pqs_chk_i (.*);

// [test/pqs_sta_model.sv]
// station management model driving the register strobes
`timescale 1ns/1ps
module pqs_sta_model
(
	input wire CLOCK, // clock
	input wire [15:0] REG_RDATA, // read data
	output reg [4:0] REG_ADDR, // register number
	output reg REG_RD, // read strobe
	output reg REG_WR, // write strobe
	output reg [15:0] REG_WDATA // write data
);
initial
begin
	REG_ADDR = 5'h00;
	REG_RD = 1'b0;
	REG_WR = 1'b0;
	REG_WDATA = 16'h0000;
end
// one access; called just after an edge
task xfer(input w, input [4:0] a, input [15:0] wd, output [15:0] d);
begin
	REG_ADDR = a;
	REG_WDATA = wd;
	REG_WR = w;
	REG_RD = !w;
	@(posedge CLOCK);
	#1;
	REG_RD = 1'b0;
	REG_WR = 1'b0;
	// released data shows no stale value
	REG_WDATA = ~wd;
	d = REG_RDATA;
	// one idle edge keeps strobe changes apart
	@(posedge CLOCK);
	#1;
end
endtask
endmodule // pqs_sta_model

// [test/testbench.sv]
// self-checking bench for the quick status register bank
`timescale 1ns/1ps
module testbench;
reg CLOCK = 0, RSTN = 0, NO_SIGNAL = 1, LINK_UP = 0;
reg STRAP_RX_FLOAT = 1, STRAP_SERIAL = 1, STRAP_AUTO_XOVER = 1, STRAP_VENDOR_GATE = 0;
reg [2:0] prog = 3'h0;
reg [15:0] ev = 16'h0000, d;
reg [21:0] rows [0:3];
integer err_count = 0, checks = 0, cyc = 0, i;
wire [4:0] REG_ADDR;
wire REG_RD, REG_WR, VENDOR_BLOCKED, AUTO_CROSSOVER_ENABLE, RECEIVE_OUTPUT_FLOAT, RX_OE_N;
wire VENDOR_SPACE_GATE, TEST_MUX_SELECT, JABBER_CHECK_OFF;
wire [15:0] REG_WDATA, REG_RDATA;
wire [1:0] BUS_MODE;
pqs_regs pqs_regs_i (.*, .AN_PROGRESS(prog), .AN_DONE(ev[4]), .SIG_LOST_EV(ev[10]),
	.PLL_ERR_EV(ev[9]), .FALSE_CARRIER_EV(ev[8]), .INVALID_SYM_EV(ev[7]),
	.HALT_SYM_EV(ev[6]), .PREMATURE_END_EV(ev[5]), .JABBER_EV(ev[2]),
	.REMOTE_FAULT_EV(ev[1]), .REMOTE_JABBER_EV(ev[15]), .POLARITY_REV_EV(ev[14]));
pqs_sta_model pqs_sta_model_i (.*);
always #5 CLOCK = ~CLOCK;
task chk(input [15:0] g, input [15:0] e);
begin
	checks = checks + 1;
	if (g !== e)
	begin
		err_count = err_count + 1;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
	end
end
endtask
task close_out;
begin
	$display("checks=%0d err_count=%0d", checks, err_count);
	if (err_count == 0 && checks > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
end
endtask
task rd(input [4:0] a);
	pqs_sta_model_i.xfer(1'b0, a, 16'h0000, d);
endtask
task pulse(input [15:0] m);
begin
	ev = m;
	@(posedge CLOCK);
	#1 ev = 16'h0000;
end
endtask
always @(posedge CLOCK)
begin
	cyc = cyc + 1;
	if (cyc == 3000)
	begin
		err_count = err_count + 1;
		close_out;
	end
end
initial
begin
	rows[0] = {16'hFFFF, 6'h3F};
	rows[1] = {16'h0A20, 6'h29};
	rows[2] = {16'h0500, 6'h16};
	rows[3] = {16'h0000, 6'h00};
	repeat (8) @(posedge CLOCK);
	#1 RSTN = 1;
	repeat (2) @(posedge CLOCK);
	#1 rd(5'h11);
	chk(d, 16'h0008);
	rd(5'h12);
	chk(d, 16'h3C10);
	chk({14'h0000, BUS_MODE}, 16'h0003);
	$display("reset test done");
	for (i = 0; i < 4; i = i + 1)
	begin
		pqs_sta_model_i.xfer(1'b1, 5'h12, rows[i][21:6], d);
		chk({AUTO_CROSSOVER_ENABLE, RECEIVE_OUTPUT_FLOAT, VENDOR_SPACE_GATE, TEST_MUX_SELECT,
			RX_OE_N, JABBER_CHECK_OFF}, rows[i][5:0]);
		rd(5'h12);
		chk(d, {4'h3, rows[i][17:14], 2'b00, rows[i][11], 1'b1, 4'h0});
	end
	$display("control table done");
	for (i = 1; i < 11; i = i + 1)
		if (16'h07E6 >> i & 1)
		begin
			pulse(16'h0001 << i);
			rd(5'h11);
			chk(d, (16'h0001 << i) | 16'h0008);
			rd(5'h11);
			chk(d, 16'h0008);
		end
	$display("latch test done");
	prog = 3'h5;
	LINK_UP = 1;
	ev[4] = 1;
	repeat (2) @(posedge CLOCK);
	#1 rd(5'h11);
	rd(5'h11);
	chk(d, 16'h2819);
	LINK_UP = 0;
	@(posedge CLOCK);
	#1 LINK_UP = 1;
	rd(5'h11);
	chk(d, 16'h2818);
	rd(5'h11);
	chk(d, 16'h2819);
	$display("link test done");
	pqs_sta_model_i.xfer(1'b1, 5'h12, 16'h0200, d);
	pulse(16'hC000);
	rd(5'h12);
	chk(d, 16'hF210);
	rd(5'h19);
	chk(d, 16'hF210);
	rd(5'h12);
	chk(d, 16'h3210);
	$display("vendor test done");
	close_out;
end
endmodule // testbench
